// File: dcr_regs.sv
// Address and byte-count register set of a two-channel DMA controller.
// Assumes CPU I/O strobes and sequencer steps are synchronous to clk_in.
`timescale 1ns/1ps
module dcr_regs
    import dcr_pkg::*;
(
    input  wire logic        clk_in,               // System clock, 200 MHz
    input  wire logic        rst_n_in,             // Chip reset, active low, async
    input  wire logic [7:0]  io_addr_in,           // CPU I/O address
    input  wire logic        io_wr_in,             // CPU I/O write strobe
    input  wire logic        io_rd_in,             // CPU I/O read strobe
    input  wire logic [7:0]  io_wdata_in,          // CPU write data
    output logic      [7:0]  io_rdata_out,         // CPU read data, registered
    input  wire logic        ch0_enable_in,        // Channel 0 enable from status
    input  wire logic        ch1_enable_in,        // Channel 1 enable from status
    input  wire logic        ch0_step_in,          // Channel 0 byte moved, pulse
    input  wire logic        ch1_step_in,          // Channel 1 byte moved, pulse
    input  wire logic [1:0]  ch0_src_mode_in,      // Channel 0 source mode
    input  wire logic [1:0]  ch0_dest_mode_in,     // Channel 0 destination mode
    input  wire logic        ch1_mem_decrement_in, // Channel 1 memory address down
    output logic      [19:0] ch0_source_address_out,      // Channel 0 source
    output logic      [19:0] ch0_destination_address_out, // Channel 0 destination
    output logic      [19:0] ch1_memory_address_out,      // Channel 1 memory side
    output logic      [15:0] ch1_io_address_out,          // Channel 1 I/O side
    output logic      [7:0]  ch1_request_selector_out,    // Channel 1 selector byte
    output logic      [1:0]  ch0_request_select_out,      // Channel 0 request source
    output logic             ch0_request_valid_out,       // Channel 0 uses a request
    output logic             timer_output_route_out,      // Shared pin to timer
    output logic             ch0_done_out,         // Channel 0 end, clear enable
    output logic             ch1_done_out          // Channel 1 end, clear enable
);

    logic        rst_meta_ff;
    logic        rst_sync_ff;
    logic [15:0] ch0_byte_count;
    logic [15:0] ch1_byte_count;
    logic [19:0] nxt_ch0_src;
    logic [19:0] nxt_ch0_dst;
    logic [19:0] nxt_ch1_mem;
    logic        ch0_take;
    logic        ch1_take;
    logic [2:0]  wr_ch0_src;
    logic [2:0]  wr_ch0_dst;
    logic [1:0]  wr_ch0_cnt;
    logic [2:0]  wr_ch1_mem;
    logic [1:0]  wr_ch1_io;
    logic [1:0]  wr_ch1_cnt;
    logic        wr_ch1_sel;
    logic [15:0] wr_hit;
    logic [7:0]  nxt_rdata;
    logic [1:0]  nxt_req_select;
    logic        nxt_req_valid;

    // Reset release through two flip-flops
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Steps only count while the channel is enabled
    assign ch0_take = ch0_step_in && ch0_enable_in;
    assign ch1_take = ch1_step_in && ch1_enable_in;

    // One strobe per mapped byte, low byte at lowest offset
    always_comb
    begin
        wr_hit = 16'h0000;
        if (io_wr_in && (io_addr_in[7:4] == OFS_CH0_SRC_ADDR_LOW[7:4]))
            wr_hit[io_addr_in[3:0]] = 1'b1;
        wr_ch0_src = wr_hit[2:0];
        wr_ch0_dst = wr_hit[5:3];
        wr_ch0_cnt = wr_hit[7:6];
        wr_ch1_mem = wr_hit[10:8];
        wr_ch1_io  = wr_hit[12:11];
        wr_ch1_sel = wr_hit[13];
        wr_ch1_cnt = wr_hit[15:14];
    end

    // Next addresses per mode
    dcr_addr_step #(.WIDTH(MEM_ADDR_WIDTH)) u_step_src
    (
        .addr_in  (ch0_source_address_out),
        .mode_in  (ch0_src_mode_in),
        .addr_out (nxt_ch0_src)
    );

    dcr_addr_step #(.WIDTH(MEM_ADDR_WIDTH)) u_step_dst
    (
        .addr_in  (ch0_destination_address_out),
        .mode_in  (ch0_dest_mode_in),
        .addr_out (nxt_ch0_dst)
    );

    dcr_addr_step #(.WIDTH(MEM_ADDR_WIDTH)) u_step_mem1
    (
        .addr_in  (ch1_memory_address_out),
        .mode_in  ({1'b0, ch1_mem_decrement_in}),
        .addr_out (nxt_ch1_mem)
    );

    // Channel 0 source address; memory, I/O or mapped I/O alike
    dcr_multibyte_reg #(.NBYTES(3), .WIDTH(MEM_ADDR_WIDTH), .RESETTABLE(1'b1),
                        .RST_VALUE(RST_MEM_ADDR)) u_ch0_src
    (
        .clk_in      (clk_in),
        .rst_n_in    (rst_sync_ff),
        .wr_en_in    (wr_ch0_src),
        .wdata_in    (io_wdata_in),
        .load_in     (ch0_take),
        .load_in_val (nxt_ch0_src),
        .value_out   (ch0_source_address_out)
    );

    // Channel 0 destination address
    dcr_multibyte_reg #(.NBYTES(3), .WIDTH(MEM_ADDR_WIDTH), .RESETTABLE(1'b1),
                        .RST_VALUE(RST_MEM_ADDR)) u_ch0_dst
    (
        .clk_in      (clk_in),
        .rst_n_in    (rst_sync_ff),
        .wr_en_in    (wr_ch0_dst),
        .wdata_in    (io_wdata_in),
        .load_in     (ch0_take),
        .load_in_val (nxt_ch0_dst),
        .value_out   (ch0_destination_address_out)
    );

    // Channel 0 byte count, no reset
    dcr_multibyte_reg #(.NBYTES(2), .WIDTH(COUNT_WIDTH), .RESETTABLE(1'b0),
                        .RST_VALUE(16'h0000)) u_ch0_cnt
    (
        .clk_in      (clk_in),
        .rst_n_in    (rst_sync_ff),
        .wr_en_in    (wr_ch0_cnt),
        .wdata_in    (io_wdata_in),
        .load_in     (ch0_take),
        .load_in_val (ch0_byte_count - 16'h0001),
        .value_out   (ch0_byte_count)
    );

    // Channel 1 memory address
    dcr_multibyte_reg #(.NBYTES(3), .WIDTH(MEM_ADDR_WIDTH), .RESETTABLE(1'b1),
                        .RST_VALUE(RST_MEM_ADDR)) u_ch1_mem
    (
        .clk_in      (clk_in),
        .rst_n_in    (rst_sync_ff),
        .wr_en_in    (wr_ch1_mem),
        .wdata_in    (io_wdata_in),
        .load_in     (ch1_take),
        .load_in_val (nxt_ch1_mem),
        .value_out   (ch1_memory_address_out)
    );

    // Channel 1 I/O address, fixed during transfers
    dcr_multibyte_reg #(.NBYTES(2), .WIDTH(IO_ADDR_WIDTH), .RESETTABLE(1'b1),
                        .RST_VALUE(RST_IO_ADDR)) u_ch1_io
    (
        .clk_in      (clk_in),
        .rst_n_in    (rst_sync_ff),
        .wr_en_in    (wr_ch1_io),
        .wdata_in    (io_wdata_in),
        .load_in     (1'b0),
        .load_in_val (ch1_io_address_out),
        .value_out   (ch1_io_address_out)
    );

    // Channel 1 byte count, no reset
    dcr_multibyte_reg #(.NBYTES(2), .WIDTH(COUNT_WIDTH), .RESETTABLE(1'b0),
                        .RST_VALUE(16'h0000)) u_ch1_cnt
    (
        .clk_in      (clk_in),
        .rst_n_in    (rst_sync_ff),
        .wr_en_in    (wr_ch1_cnt),
        .wdata_in    (io_wdata_in),
        .load_in     (ch1_take),
        .load_in_val (ch1_byte_count - 16'h0001),
        .value_out   (ch1_byte_count)
    );

    // Channel 1 selector byte
    always_ff @(posedge clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            ch1_request_selector_out <= RST_CH1_REQUEST_SELECT;
        else if (wr_ch1_sel)
            ch1_request_selector_out <= io_wdata_in;
    end

    // Shared pin routing follows selector bit 3
    always_ff @(posedge clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            timer_output_route_out <= 1'b0;
        else if (wr_ch1_sel)
            timer_output_route_out <= io_wdata_in[SEL_TIMER_BIT];
    end

    // Request source of channel 0 from the I/O side
    always_comb
    begin
        nxt_req_valid  = 1'b0;
        nxt_req_select = REQ_EXTERNAL_0;
        if (ch0_src_mode_in == DCR_MODE_IO_FIXED)
        begin
            nxt_req_select = ch0_source_address_out[REQ_FIELD_LSB +: 2];
            nxt_req_valid  = (nxt_req_select != REQ_UNUSED);
        end
        else if (ch0_dest_mode_in == DCR_MODE_IO_FIXED)
        begin
            nxt_req_select = ch0_destination_address_out[REQ_FIELD_LSB +: 2];
            nxt_req_valid  = (nxt_req_select != REQ_UNUSED);
        end
    end

    // Registered request selection
    always_ff @(posedge clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            ch0_request_select_out <= REQ_EXTERNAL_0;
            ch0_request_valid_out  <= 1'b0;
        end
        else
        begin
            ch0_request_select_out <= nxt_req_select;
            ch0_request_valid_out  <= nxt_req_valid;
        end
    end

    // End of transfer when the last byte is counted
    always_ff @(posedge clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            ch0_done_out <= 1'b0;
            ch1_done_out <= 1'b0;
        end
        else
        begin
            ch0_done_out <= ch0_take && (ch0_byte_count == COUNT_LAST);
            ch1_done_out <= ch1_take && (ch1_byte_count == COUNT_LAST);
        end
    end

    // Read multiplexer, showing stepped values
    always_comb
    begin
        case (io_addr_in)
            OFS_CH0_SRC_ADDR_LOW:   nxt_rdata = ch0_source_address_out[7:0];
            OFS_CH0_SRC_ADDR_HIGH:  nxt_rdata = ch0_source_address_out[15:8];
            OFS_CH0_SRC_ADDR_UPPER: nxt_rdata = {4'h0, ch0_source_address_out[19:16]};
            OFS_CH0_DST_ADDR_LOW:   nxt_rdata = ch0_destination_address_out[7:0];
            OFS_CH0_DST_ADDR_HIGH:  nxt_rdata = ch0_destination_address_out[15:8];
            OFS_CH0_DST_ADDR_UPPER: nxt_rdata = {4'h0, ch0_destination_address_out[19:16]};
            OFS_CH0_COUNT_LOW:      nxt_rdata = ch0_byte_count[7:0];
            OFS_CH0_COUNT_HIGH:     nxt_rdata = ch0_byte_count[15:8];
            OFS_CH1_MEM_ADDR_LOW:   nxt_rdata = ch1_memory_address_out[7:0];
            OFS_CH1_MEM_ADDR_HIGH:  nxt_rdata = ch1_memory_address_out[15:8];
            OFS_CH1_MEM_ADDR_UPPER: nxt_rdata = {4'h0, ch1_memory_address_out[19:16]};
            OFS_CH1_IO_ADDR_LOW:    nxt_rdata = ch1_io_address_out[7:0];
            OFS_CH1_IO_ADDR_HIGH:   nxt_rdata = ch1_io_address_out[15:8];
            OFS_CH1_REQUEST_SELECT: nxt_rdata = ch1_request_selector_out;
            OFS_CH1_COUNT_LOW:      nxt_rdata = ch1_byte_count[7:0];
            OFS_CH1_COUNT_HIGH:     nxt_rdata = ch1_byte_count[15:8];
            default:                nxt_rdata = UNMAPPED_READ_DATA;
        endcase
    end

    // Read data register, captured on the read strobe
    always_ff @(posedge clk_in or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            io_rdata_out <= RST_READ_DATA;
        else if (io_rd_in)
            io_rdata_out <= nxt_rdata;
    end

endmodule : dcr_regs

// File: dcr_pkg.sv
// Constants for the DMA address and byte-count register set.
// Assumes an 8-bit CPU I/O address space and one 200 MHz system clock.
package dcr_pkg;

    // I/O offsets of the byte registers
    localparam logic [7:0] OFS_CH0_SRC_ADDR_LOW   = 8'h20;
    localparam logic [7:0] OFS_CH0_SRC_ADDR_HIGH  = 8'h21;
    localparam logic [7:0] OFS_CH0_SRC_ADDR_UPPER = 8'h22;
    localparam logic [7:0] OFS_CH0_DST_ADDR_LOW   = 8'h23;
    localparam logic [7:0] OFS_CH0_DST_ADDR_HIGH  = 8'h24;
    localparam logic [7:0] OFS_CH0_DST_ADDR_UPPER = 8'h25;
    localparam logic [7:0] OFS_CH0_COUNT_LOW      = 8'h26;
    localparam logic [7:0] OFS_CH0_COUNT_HIGH     = 8'h27;
    localparam logic [7:0] OFS_CH1_MEM_ADDR_LOW   = 8'h28;
    localparam logic [7:0] OFS_CH1_MEM_ADDR_HIGH  = 8'h29;
    localparam logic [7:0] OFS_CH1_MEM_ADDR_UPPER = 8'h2a;
    localparam logic [7:0] OFS_CH1_IO_ADDR_LOW    = 8'h2b;
    localparam logic [7:0] OFS_CH1_IO_ADDR_HIGH   = 8'h2c;
    localparam logic [7:0] OFS_CH1_REQUEST_SELECT = 8'h2d;
    localparam logic [7:0] OFS_CH1_COUNT_LOW      = 8'h2e;
    localparam logic [7:0] OFS_CH1_COUNT_HIGH     = 8'h2f;

    // Widths
    localparam int MEM_ADDR_WIDTH = 20;
    localparam int IO_ADDR_WIDTH  = 16;
    localparam int COUNT_WIDTH    = 16;

    // Values after reset and for unmapped reads
    localparam logic [7:0]  RST_CH1_REQUEST_SELECT = 8'h00;
    localparam logic [19:0] RST_MEM_ADDR           = 20'h00000;
    localparam logic [15:0] RST_IO_ADDR            = 16'h0000;
    localparam logic [7:0]  RST_READ_DATA          = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ_DATA     = 8'h00;

    // Field positions
    localparam int REQ_FIELD_LSB   = 16;   // A17..A16 pick the request
    localparam int SEL_TIMER_BIT   = 3;    // Selector bit routing the shared pin

    // Address stepping modes of channel 0
    typedef enum logic [1:0]
    {
        DCR_MODE_MEM_INC   = 2'b00,
        DCR_MODE_MEM_DEC   = 2'b01,
        DCR_MODE_MEM_FIXED = 2'b10,
        DCR_MODE_IO_FIXED  = 2'b11
    } dcr_mode_t;

    // Request sources chosen by A17..A16
    localparam logic [1:0] REQ_EXTERNAL_0 = 2'b00;
    localparam logic [1:0] REQ_SERIAL0_TX = 2'b01;
    localparam logic [1:0] REQ_SERIAL1_TX = 2'b10;
    localparam logic [1:0] REQ_UNUSED     = 2'b11;

    localparam logic [15:0] COUNT_LAST = 16'h0001;  // Count value before the final byte

endpackage : dcr_pkg

// File: dcr_addr_step.sv
// Next-address calculation for one stepped address register.
// Assumes the mode is stable while a byte step is in progress.
`timescale 1ns/1ps
module dcr_addr_step
    import dcr_pkg::*;
#(
    parameter int WIDTH = 20
)
(
    input  wire logic [WIDTH-1:0] addr_in,     // Current address
    input  wire logic [1:0]       mode_in,     // Stepping mode
    output logic      [WIDTH-1:0] addr_out     // Address after one byte
);

    // Increment, decrement or hold
    always_comb
    begin
        case (mode_in)
            DCR_MODE_MEM_INC:   addr_out = addr_in + WIDTH'(1);
            DCR_MODE_MEM_DEC:   addr_out = addr_in - WIDTH'(1);
            default:            addr_out = addr_in;
        endcase
    end

endmodule : dcr_addr_step

// File: dcr_multibyte_reg.sv
// Multi-byte register written a byte at a time and loaded whole by hardware.
// Assumes byte enables and the load come from the same clock domain.
`timescale 1ns/1ps
module dcr_multibyte_reg
#(
    parameter int              NBYTES     = 3,
    parameter int              WIDTH      = 20,
    parameter bit              RESETTABLE = 1'b1,
    parameter logic [WIDTH-1:0] RST_VALUE = '0
)
(
    input  wire logic              clk_in,      // System clock
    input  wire logic              rst_n_in,    // Synchronised reset, active low
    input  wire logic [NBYTES-1:0] wr_en_in,    // Per-byte write strobe
    input  wire logic [7:0]        wdata_in,    // Write data
    input  wire logic              load_in,     // Hardware step load
    input  wire logic [WIDTH-1:0]  load_in_val, // Stepped value
    output logic      [WIDTH-1:0]  value_out    // Current value
);

    // One slice per byte; a byte write wins over a step of the same byte
    genvar i;
    generate
        for (i = 0; i < NBYTES; i++)
        begin : g_byte
            localparam int LSB = 8 * i;
            localparam int BW  = (i == NBYTES - 1) ? WIDTH - LSB : 8;
            if (RESETTABLE)
            begin : g_rst
                always_ff @(posedge clk_in or negedge rst_n_in)
                begin
                    if (!rst_n_in)
                        value_out[LSB +: BW] <= RST_VALUE[LSB +: BW];
                    else if (wr_en_in[i])
                        value_out[LSB +: BW] <= wdata_in[BW-1:0];
                    else if (load_in)
                        value_out[LSB +: BW] <= load_in_val[LSB +: BW];
                end
            end
            else
            begin : g_norst
                // Left uninitialised by reset on purpose
                always_ff @(posedge clk_in)
                begin
                    if (wr_en_in[i])
                        value_out[LSB +: BW] <= wdata_in[BW-1:0];
                    else if (load_in)
                        value_out[LSB +: BW] <= load_in_val[LSB +: BW];
                end
            end
        end
    endgenerate

endmodule : dcr_multibyte_reg

// File: dcr_regs_chk.sv
// Assertions on the ports of the DMA address and count register set.
// Assumes one clock domain; bound to every dcr_regs instance.
`timescale 1ns/1ps
module dcr_regs_chk
    import dcr_pkg::*;
(
    input wire logic        clk_in,                      // Clock
    input wire logic        rst_n_in,                    // Reset
    input wire logic [7:0]  io_addr_in,                  // Address
    input wire logic        io_wr_in,                    // Write
    input wire logic        io_rd_in,                    // Read
    input wire logic [7:0]  io_wdata_in,                 // Write data
    input wire logic [7:0]  io_rdata_out,                // Read data
    input wire logic        ch0_enable_in,               // Enable
    input wire logic        ch0_step_in,                 // Step
    input wire logic [1:0]  ch0_src_mode_in,             // Source mode
    input wire logic [1:0]  ch0_dest_mode_in,            // Dest mode
    input wire logic [19:0] ch0_source_address_out,      // Source
    input wire logic [19:0] ch0_destination_address_out, // Destination
    input wire logic [7:0]  ch1_request_selector_out,    // Selector
    input wire logic [1:0]  ch0_request_select_out,      // Request code
    input wire logic        ch0_request_valid_out,       // Request used
    input wire logic        timer_output_route_out,      // Timer route
    input wire logic        ch0_done_out                 // Done
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Writes aimed at the channel 0 address registers
    wire wr_src = io_wr_in && io_addr_in >= 8'h20 && io_addr_in <= 8'h22;
    wire wr_dst = io_wr_in && io_addr_in >= 8'h23 && io_addr_in <= 8'h25;

    sequence s_step0;
        ch0_step_in && ch0_enable_in;
    endsequence
    sequence s_src_io;
        ch0_src_mode_in == 2'b11 && $stable(ch0_source_address_out);
    endsequence

    property p_src_inc;
        s_step0 ##0 (ch0_src_mode_in == 2'b00 && !wr_src)
        |=> ch0_source_address_out == $past(ch0_source_address_out) + 20'h1;
    endproperty
    property p_dst_dec;
        s_step0 ##0 (ch0_dest_mode_in == 2'b01 && !wr_dst)
        |=> ch0_destination_address_out == $past(ch0_destination_address_out) - 20'h1;
    endproperty
    property p_src_fixed;
        s_step0 ##0 (ch0_src_mode_in[1] && !wr_src) |=> $stable(ch0_source_address_out);
    endproperty
    property p_src_idle;
        !(ch0_step_in && ch0_enable_in) && !wr_src |=> $stable(ch0_source_address_out);
    endproperty
    property p_sel_wr;
        io_wr_in && io_addr_in == OFS_CH1_REQUEST_SELECT
        |=> ch1_request_selector_out == $past(io_wdata_in);
    endproperty
    property p_timer;
        timer_output_route_out == ch1_request_selector_out[SEL_TIMER_BIT];
    endproperty
    property p_req;
        s_src_io[*2] |-> ch0_request_select_out == ch0_source_address_out[17:16];
    endproperty
    property p_req_valid;
        s_src_io[*2] |-> ch0_request_valid_out == (ch0_source_address_out[17:16] != 2'b11);
    endproperty
    property p_rd_unmapped;
        io_rd_in && (io_addr_in < 8'h20 || io_addr_in > 8'h2f)
        |=> io_rdata_out == UNMAPPED_READ_DATA;
    endproperty
    property p_rd_hold;
        !io_rd_in |=> $stable(io_rdata_out);
    endproperty
    property p_done;
        ch0_done_out |-> $past(ch0_step_in && ch0_enable_in);
    endproperty

    a_src_inc:      assert property (p_src_inc) else $error("source not incremented");
    a_dst_dec:      assert property (p_dst_dec) else $error("dest not decremented");
    a_src_fixed:    assert property (p_src_fixed) else $error("fixed source moved");
    a_src_idle:     assert property (p_src_idle) else $error("source moved unasked");
    a_sel_wr:       assert property (p_sel_wr) else $error("selector write lost");
    a_timer:        assert property (p_timer) else $error("timer route wrong");
    a_req:          assert property (p_req) else $error("request code wrong");
    a_req_valid:    assert property (p_req_valid) else $error("request valid wrong");
    a_rd_unmapped:  assert property (p_rd_unmapped) else $error("unmapped read nonzero");
    a_rd_hold:      assert property (p_rd_hold) else $error("read data moved");
    a_done:         assert property (p_done) else $error("done without step");
endmodule : dcr_regs_chk

bind dcr_regs dcr_regs_chk u_chk (.*);

// File: dcr_seq_model.sv
// Behavioural transfer sequencer that enables a channel and pulses byte steps.
// Assumes the count was loaded by software before start_in.
`timescale 1ns/1ps
module dcr_seq_model
(
    input  wire logic        clk_in,     // System clock
    input  wire logic        start_in,   // Begin one transfer
    input  wire logic [15:0] nbytes_in,  // Bytes to move
    input  wire logic [3:0]  gap_in,     // Idle cycles between bytes, less one
    input  wire logic        done_in,    // End of transfer
    output logic             enable_out = 1'b0, // Channel enable
    output logic             step_out = 1'b0,   // One byte moved
    output logic             busy_out = 1'b0    // Transfer running
);
    // One transfer per start, stray step first while still disabled
    always @(posedge clk_in)
    begin
        if (start_in)
        begin
            busy_out <= 1'b1;
            step_out <= 1'b1;
            @(posedge clk_in);
            step_out   <= 1'b0;
            enable_out <= 1'b1;
            for (int i = 0; i < nbytes_in; i++)
            begin
                @(posedge clk_in);
                step_out <= 1'b1;
                @(posedge clk_in);
                step_out <= 1'b0;
                repeat (gap_in) @(posedge clk_in);
            end
            for (int k = 0; k < 8 && !done_in; k++) @(posedge clk_in);
            @(posedge clk_in);
            enable_out <= 1'b0;
            busy_out   <= 1'b0;
        end
    end
endmodule : dcr_seq_model

// File: dcr_regs_tb.sv
// Self-checking bench for the DMA address and count register set.
// Assumes dcr_regs, dcr_seq_model and the bound checker are compiled first.
`timescale 1ns/1ps
module dcr_regs_tb
    import dcr_pkg::*;
;
    logic        clk_in = 1'b0, rst_n_in = 1'b0, io_wr_in = 1'b0, io_rd_in = 1'b0;
    logic [7:0]  io_addr_in = 8'h00, io_wdata_in = 8'h00, io_rdata_out;
    logic        en0, en1, st0, st1, bz0, bz1, dec_in = 1'b0, go0 = 1'b0, go1 = 1'b0;
    logic [1:0]  sm = 2'b00, dm = 2'b00, rq;
    logic [15:0] nb = 16'h0002, iao;
    logic [3:0]  gap = 4'h0;
    logic [19:0] sa, da, ma;
    logic [7:0]  sel, d;
    logic        rv, tr, dn0, dn1;
    int          n_fail = 0, num_checks = 0, c0 = 0, c1 = 0;

    // Clock and done pulse tallies
    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        c0 <= c0 + int'(dn0 === 1'b1);
        c1 <= c1 + int'(dn1 === 1'b1);
    end

    dcr_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .io_addr_in(io_addr_in),
        .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in),
        .io_rdata_out(io_rdata_out), .ch0_enable_in(en0), .ch1_enable_in(en1),
        .ch0_step_in(st0), .ch1_step_in(st1), .ch0_src_mode_in(sm), .ch0_dest_mode_in(dm),
        .ch1_mem_decrement_in(dec_in), .ch0_source_address_out(sa),
        .ch0_destination_address_out(da), .ch1_memory_address_out(ma),
        .ch1_io_address_out(iao), .ch1_request_selector_out(sel),
        .ch0_request_select_out(rq), .ch0_request_valid_out(rv),
        .timer_output_route_out(tr), .ch0_done_out(dn0), .ch1_done_out(dn1));
    dcr_seq_model m0 (.clk_in(clk_in), .start_in(go0), .nbytes_in(nb), .gap_in(gap),
        .done_in(dn0), .enable_out(en0), .step_out(st0), .busy_out(bz0));
    dcr_seq_model m1 (.clk_in(clk_in), .start_in(go1), .nbytes_in(nb), .gap_in(gap),
        .done_in(dn1), .enable_out(en1), .step_out(st1), .busy_out(bz1));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_in);
        io_wr_in <= 1'b1; io_addr_in <= a; io_wdata_in <= v;
        @(posedge clk_in);
        io_wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_in);
        io_rd_in <= 1'b1; io_addr_in <= a;
        @(posedge clk_in);
        io_rd_in <= 1'b0;
        #1 v = io_rdata_out;
    endtask : rd

    task automatic wr_reg(input logic [7:0] a, input int n, input logic [23:0] v);
        for (int i = 0; i < n; i++) wr(a + 8'(i), v[8*i +: 8]);
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input int n, output logic [23:0] v);
        v = '0;
        for (int i = 0; i < n; i++) begin rd(a + 8'(i), d); v[8*i +: 8] = d; end
    endtask : rd_reg

    // Start one transfer on a channel and wait for its end, bounded
    task automatic run(input bit ch);
        int k;
        @(posedge clk_in);
        if (ch) go1 <= 1'b1; else go0 <= 1'b1;
        @(posedge clk_in);
        go0 <= 1'b0; go1 <= 1'b0;
        @(posedge clk_in);
        for (k = 0; k < 300 && (ch ? bz1 : bz0) !== 1'b0; k++) @(posedge clk_in);
        if (k == 300) begin n_fail++; end_sim(); end
    endtask : run

    function automatic logic [19:0] stp(logic [19:0] a, logic [1:0] m);
        return (m == 2'b00) ? a + 20'h2 : (m == 2'b01) ? a - 20'h2 : a;
    endfunction : stp

    task automatic t_map;
        logic [23:0] v;
        logic [7:0]  x;
        for (int i = 0; i < 16; i++) wr(8'h20 + 8'(i), 8'(i * 23 + 3));
        for (int i = 0; i < 16; i++)
        begin
            x = 8'(i * 23 + 3);
            if (i == 2 || i == 5 || i == 10) x[7:4] = 4'h0;
            rd_reg(8'h20 + 8'(i), 1, v);
            chk("byte", v, {16'h0, x});
        end
        chk("src", sa, 20'h11a03);
        chk("dst", da, 20'h65f48);
        chk("mem", ma, 20'h9d2bb);
        chk("io", iao, 16'h1700);
        chk("timer", tr, 1'b1);
        wr(8'h30, 8'h55);
        rd(8'h30, x);
        chk("unmapped", x, 8'h00);
        wr(OFS_CH1_REQUEST_SELECT, 8'h08);
        #1 chk("timer on", {sel, 7'h0, tr}, 16'h0801);
        wr(OFS_CH1_REQUEST_SELECT, 8'h00);
        #1 chk("timer off", {sel, 7'h0, tr}, 16'h0);
    endtask : t_map

    // Two-byte channel 0 transfer in every source and destination mode
    task automatic t_ch0(input logic [1:0] m);
        logic [23:0] v;
        sm <= m; dm <= m + 2'b01; gap <= 4'(m);
        wr_reg(8'h20, 3, 24'h0ffff);
        wr_reg(8'h23, 3, 24'h0ffff);
        wr_reg(8'h26, 2, 24'h2);
        c0 = 0;
        run(1'b0);
        chk("src step", sa, stp(20'h0ffff, m));
        chk("dst step", da, stp(20'h0ffff, m + 2'b01));
        rd_reg(8'h26, 2, v);
        chk("count", v, 24'h0);
        chk("done0", 24'(c0), 24'h1);
    endtask : t_ch0

    task automatic t_req;
        sm <= 2'b11; dm <= 2'b00;
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h22, 8'(12 + c));
            repeat (3) @(posedge clk_in);
            chk("req", {rv, rq}, {c != 3, 2'(c)});
        end
    endtask : t_req

    task automatic t_ch1(input logic dn, input logic [19:0] exp);
        logic [23:0] v;
        dec_in <= dn; gap <= 4'h0;
        wr_reg(8'h2e, 2, 24'h1);
        c1 = 0;
        run(1'b1);
        chk("mem step", ma, exp);
        chk("io kept", iao, 16'h1234);
        rd_reg(8'h2e, 2, v);
        chk("count1", v, 24'h0);
        chk("done1", 24'(c1), 24'h1);
    endtask : t_ch1

    initial
    begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("rst addr", {sa ^ da ^ ma, sel}, 28'h0);
        chk("rst misc", {iao, tr, io_rdata_out}, 25'h0);
        t_map();
        for (int m = 0; m < 4; m++) t_ch0(2'(m));
        t_req();
        nb <= 16'h1;
        wr_reg(8'h28, 3, 24'h10000);
        wr_reg(8'h2b, 2, 24'h1234);
        t_ch1(1'b1, 20'h0ffff);
        t_ch1(1'b0, 20'h10000);
        end_sim();
    end
endmodule : dcr_regs_tb
